// file: verilog/upmsc_consts.vh
// Constants for the USB port manual switch control block
`ifndef UPMSC_CONSTS_VH
`define UPMSC_CONSTS_VH
`define UPMSC_ADDR_SWITCH_CONTROL 8'h02
`define UPMSC_ADDR_MANUAL_PATH 8'h13
`define UPMSC_CTRL_MANUAL 8'h1A
`define UPMSC_CTRL_AUTO 8'h1E
`define UPMSC_CTRL_RESET 8'h1E
`define UPMSC_MANUAL_RESET 8'h00
`define UPMSC_PATH_FS_UART 8'h6C
`define UPMSC_ROUTE_OPEN 2'h0
`define UPMSC_ROUTE_USB 2'h1
`define UPMSC_ROUTE_UART 2'h2
`endif

// file: verilog/upmsc_ocp_latch.v
// Over-current latch on the bus power output
`timescale 1ns/100ps
module upmsc_ocp_latch (
  // Clock and reset
  input wire core_clk_in,
  input wire reset_in,
  input wire clk_en_in,
  // Monitor
  input wire overcurrent_trip_in,
  input wire load_present_in,
  // Result
  output reg overcurrent_latch_out
);
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      overcurrent_latch_out <= 1'b0;
    end else if (clk_en_in) begin
      // [RULE7] Trip wins over release
      if (overcurrent_trip_in) begin
        overcurrent_latch_out <= 1'b1;
      end else if (!load_present_in) begin
        overcurrent_latch_out <= 1'b0;
      end
    end
  end
endmodule

// file: verilog/upmsc_top.v
// USB port manual switch control: register bank and switch routing
`timescale 1ns/100ps
`include "upmsc_consts.vh"
// Behaviour
// [RULE1] USB attach in automatic mode routes connector data to host USB pins.
// [RULE2] Writing 0x1A to control enters manual mode, opening every path at once.
// [RULE3] Host waits over 125 us before writing 0x6C to manual switch.
// [RULE4] Manual mode with 0x6C routes UART receive to D+, transmit to D-.
// [RULE5] Writing 0x1E to control returns to automatic switching.
// [RULE6] Host starts the manual sequence only after attach is signalled.
// [RULE7] Over-current trip latches until the load is removed; the latch clears at the next enabled clock edge with load_present_in low and no trip.
// [RULE8] In manual mode paths follow only the manual switch register; a repeat 0x1A write to control still opens both routes for one cycle.
module upmsc_top (
  // Clock and reset
  input wire core_clk_in,
  input wire reset_in,
  input wire clk_en_in,
  // Register port
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  // Detection and power
  input wire usb_attach_in,
  input wire overcurrent_trip_in,
  input wire load_present_in,
  // Status
  output reg usb_attached_out,
  output wire manual_mode_out,
  output wire overcurrent_latch_out,
  // Switch routing
  output reg [1:0] connector_dplus_route_out,
  output reg [1:0] connector_dminus_route_out
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  // Stored registers
  reg [7:0] switch_control;
  reg [7:0] manual_path_select;

  // Next values
  reg [7:0] next_switch_control;
  reg [7:0] next_manual_path_select;
  reg [7:0] next_rdata;
  reg next_usb_attached;
  reg [1:0] next_route;
  reg [1:0] next_dplus_route;
  reg [1:0] next_dminus_route;

  // Decoded strobes and codes
  wire wr_control;
  wire wr_manual;
  wire enter_manual;
  wire path_is_uart;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // Strobes qualified by address only; enable gates the flops
  assign wr_control = reg_wr_in && (reg_addr_in == `UPMSC_ADDR_SWITCH_CONTROL);
  assign wr_manual = reg_wr_in && (reg_addr_in == `UPMSC_ADDR_MANUAL_PATH);

  // [RULE2] Entry write seen early
  assign enter_manual = wr_control && (reg_wdata_in == `UPMSC_CTRL_MANUAL);

  // [RULE4] Only the full-speed code has a path
  assign path_is_uart = (manual_path_select == `UPMSC_PATH_FS_UART);

  // ----------------------------------------
  // Mode status
  // ----------------------------------------
  // [RULE2] Manual when control holds 0x1A
  assign manual_mode_out = (switch_control == `UPMSC_CTRL_MANUAL);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // [RULE5] Any value but 0x1A means automatic
  always @* begin
    next_switch_control = switch_control;
    if (wr_control) begin
      next_switch_control = reg_wdata_in;
    end
  end

  // A write that lands with enable low is lost
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      switch_control <= `UPMSC_CTRL_RESET;
    end else if (clk_en_in) begin
      switch_control <= next_switch_control;
    end
  end

  // ----------------------------------------
  // Manual path register
  // ----------------------------------------
  // Kept across mode changes, so a re-entry reuses it
  always @* begin
    next_manual_path_select = manual_path_select;
    if (wr_manual) begin
      next_manual_path_select = reg_wdata_in;
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      manual_path_select <= `UPMSC_MANUAL_RESET;
    end else if (clk_en_in) begin
      manual_path_select <= next_manual_path_select;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Unmapped addresses read as zero
  always @* begin
    next_rdata = reg_rdata_out;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `UPMSC_ADDR_SWITCH_CONTROL: begin
          next_rdata = switch_control;
        end
        `UPMSC_ADDR_MANUAL_PATH: begin
          next_rdata = manual_path_select;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Read data holds until the next read strobe
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------
  // Attach status
  // ----------------------------------------
  // Registered so the host sees one clean level
  always @* begin
    next_usb_attached = usb_attach_in;
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      usb_attached_out <= 1'b0;
    end else if (clk_en_in) begin
      usb_attached_out <= next_usb_attached;
    end
  end

  // ----------------------------------------
  // Route selection
  // ----------------------------------------
  // Unknown manual codes stay open rather than guess a path
  always @* begin
    next_route = `UPMSC_ROUTE_OPEN;
    if (manual_mode_out) begin
      // [RULE8] Manual register only
      // [RULE4] FS over UART path
      if (path_is_uart) begin
        next_route = `UPMSC_ROUTE_UART;
      end
    end else if (usb_attach_in) begin
      // [RULE1] Automatic USB attach
      next_route = `UPMSC_ROUTE_USB;
    end
  end

  // [RULE2] Entry write breaks the old path at once
  always @* begin
    next_dplus_route = next_route;
    next_dminus_route = next_route;
    if (enter_manual) begin
      next_dplus_route = `UPMSC_ROUTE_OPEN;
      next_dminus_route = `UPMSC_ROUTE_OPEN;
    end
  end

  // ----------------------------------------
  // Route flops
  // ----------------------------------------
  // Enable low holds the routes as they are
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      connector_dplus_route_out <= `UPMSC_ROUTE_OPEN;
    end else if (clk_en_in) begin
      connector_dplus_route_out <= next_dplus_route;
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      connector_dminus_route_out <= `UPMSC_ROUTE_OPEN;
    end else if (clk_en_in) begin
      connector_dminus_route_out <= next_dminus_route;
    end
  end

  // ----------------------------------------
  // Over-current
  // ----------------------------------------
  // [RULE7] Latched protection state
  upmsc_ocp_latch u_ocp (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .overcurrent_trip_in(overcurrent_trip_in),
    .load_present_in(load_present_in),
    .overcurrent_latch_out(overcurrent_latch_out)
  );
endmodule

// file: verif/upmsc_asserts.sv
// Port checker for the switch control block
`timescale 1ns/100ps
module upmsc_chk (
  // Clock and reset
  input wire core_clk_in,
  input wire reset_in,
  input wire clk_en_in,
  // Watched ports
  input wire reg_wr_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire usb_attach_in,
  input wire overcurrent_trip_in,
  input wire manual_mode_out,
  input wire overcurrent_latch_out,
  input wire [1:0] connector_dplus_route_out,
  input wire [1:0] connector_dminus_route_out
);
  wire w2 = reg_wr_in && reg_addr_in == 8'h02;
  wire [3:0] rt = {connector_dplus_route_out, connector_dminus_route_out};
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  a_usb_auto_path: assert property (
    clk_en_in && !manual_mode_out && !reg_wr_in && usb_attach_in |=> rt == 4'h5)
    else $error("no usb path");
  a_manual_opens: assert property (
    clk_en_in && w2 && reg_wdata_in == 8'h1A |=> manual_mode_out && rt == 4'h0)
    else $error("not open");
  a_uart_path: assert property (clk_en_in && reg_wr_in && reg_addr_in == 8'h13
    && reg_wdata_in == 8'h6C && manual_mode_out ##1 clk_en_in && !reg_wr_in |=> rt == 4'hA)
    else $error("uart");
  a_auto_return: assert property (
    clk_en_in && w2 && reg_wdata_in == 8'h1E ##1 clk_en_in && !reg_wr_in && usb_attach_in
    |=> rt == 4'h5) else $error("auto");
  a_latch_sets: assert property (
    clk_en_in && overcurrent_trip_in |=> overcurrent_latch_out) else $error("latch not set");
  a_manual_steady: assert property (
    clk_en_in && $past(clk_en_in) && manual_mode_out && !reg_wr_in && !$past(reg_wr_in)
    |=> $stable(rt)) else $error("moved");
endmodule
bind upmsc_top upmsc_chk u_chk (.*);

// file: verif/upmsc_host.sv
// Host processor model on the register port
`timescale 1ns/100ps
module upmsc_host (
  // Clock and status
  input wire core_clk_in,
  input wire usb_attached_in,
  // Register port
  output reg reg_wr_out = 1'b0,
  output reg reg_rd_out = 1'b0,
  output reg [7:0] reg_addr_out = 8'h00,
  output reg [7:0] reg_wdata_out = 8'h00
);
  task acc(input bit r, input [7:0] a, input [7:0] d);
    @(posedge core_clk_in) #2;
    {reg_rd_out, reg_wr_out, reg_addr_out, reg_wdata_out} = {r, !r, a, d};
    @(posedge core_clk_in) #2;
    {reg_rd_out, reg_wr_out} = 2'h0;
    // Stale data inverted so nothing reads it by luck
    reg_wdata_out = ~d;
  endtask
  task fs_on;
    wait (usb_attached_in === 1'b1);
    acc(0, 8'h02, 8'h1A);
  endtask
endmodule

// file: verif/usb_port_manual_switch_ctrl_tb_top.sv
// Self-checking bench for the switch control block
`timescale 1ns/100ps
module usb_port_manual_switch_ctrl_tb_top;
  reg clk = 0, rst = 1, att = 0, trip = 0, load = 1, en = 1;
  reg [7:0] pv = 8'h00;
  integer exp_q[$];
  wire wr, rd, man, lat, atd;
  wire [7:0] ad, wd, rdat;
  wire [1:0] dp, dm;
  integer bad_count = 0, checks = 0, cyc = 0, mode = 0;
  initial forever #12.5 clk = ~clk;
  upmsc_host HOST (.core_clk_in(clk), .usb_attached_in(atd), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_addr_out(ad), .reg_wdata_out(wd));
  upmsc_top DUT (.core_clk_in(clk), .reset_in(rst), .clk_en_in(en), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(ad), .reg_wdata_in(wd), .reg_rdata_out(rdat),
    .usb_attach_in(att), .overcurrent_trip_in(trip), .load_present_in(load),
    .usb_attached_out(atd), .manual_mode_out(man), .overcurrent_latch_out(lat),
    .connector_dplus_route_out(dp), .connector_dminus_route_out(dm));
  task chk(input string n, input [7:0] s, input [7:0] e);
    checks = checks + 1;
    if (s !== e) begin
      bad_count = bad_count + 1;
      $display("wrong value %s exp %h saw %h", n, e, s);
    end
  endtask
  // Expected routes: 0 auto, 1 manual open, 2 manual uart
  task rte;
    chk("routes", {4'h0, dp, dm}, mode == 2 ? 8'h0A : (mode == 0 && att ? 8'h05 : 8'h00));
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task print_verdict;
    $display("checks %0d wrong %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) if (++cyc > 20000) begin bad_count++; print_verdict; end
  initial begin
    void'($urandom(32'h12D3F984));
    tick(5);
    rst = 0;
    HOST.acc(1, 8'h02, 8'h00);
    chk("control", rdat, 8'h1E);
    HOST.acc(1, 8'h20 + $urandom % 8'hD0, 8'h00);
    chk("unmapped", rdat, 8'h00);
    $display("reset test done");
    att = 1;
    tick(2);
    rte;
    chk("attached", atd, 8'h01);
    HOST.fs_on;
    mode = 1;
    rte;
    chk("manual", man, 8'h01);
    pv = $urandom % 8'h6C;
    exp_q.push_back(pv);
    HOST.acc(0, 8'h13, pv);
    HOST.acc(1, 8'h13, 8'h00);
    chk("path", rdat, exp_q.pop_front());
    att = 0;
    tick(2);
    rte;
    att = 1;
    tick(5001);
    HOST.acc(0, 8'h13, 8'h6C);
    mode = 2;
    tick(1);
    rte;
    HOST.acc(0, 8'h02, 8'h1E);
    mode = 0;
    tick(1);
    rte;
    chk("manual", man, 8'h00);
    $display("manual test done");
    en = 0;
    HOST.acc(0, 8'h02, 8'h1A);
    tick(1);
    chk("frozen", man, 8'h00);
    rte;
    en = 1;
    tick(1);
    rte;
    $display("enable test done");
    trip = 1;
    tick(1);
    trip = 0;
    tick(3);
    chk("latch", lat, 1);
    load = 0;
    tick(2);
    chk("latch", lat, 0);
    $display("latch test done");
    print_verdict;
  end
endmodule
